// ### logic/idcw_top.sv
`timescale 1ns/1ps
`default_nettype none
module idcw_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,                    // Hot system reset
    input  wire logic        power_on_rstn,              // Cold power-up reset
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [63:0] isolated_input_channel,     // High when energised
    output logic      [63:0] isolated_output_channel,
    input  wire logic [31:0] ttl_channel_i,
    output logic      [31:0] ttl_channel_o,
    output logic      [31:0] ttl_channel_oe,
    input  wire logic [3:0]  board_id_switch_on,         // High when switch is ON
    output logic             irq
);
    idcw_pkg::idcw_core_s q;
    idcw_pkg::idcw_core_s d;
    idcw_pkg::idcw_keep_s k_q;
    idcw_pkg::idcw_keep_s k_d;

    logic [63:0] in_level;     // Both banks, displayed polarity
    logic [63:0] in_latch;     // Both banks, captured words
    logic [1:0]  bank_pend;    // Bank requests
    logic [1:0]  bank_clr;     // Bank clear pulses
    logic        setup;        // APB setup cycle
    logic        wr;           // APB write taking effect
    logic        tick;         // One watchdog step
    logic        ovf;          // Watchdog runs out this cycle
    logic [31:0] rd;           // Read mux output
    logic        err;          // Unmapped address
    logic        wdt_clr;      // Watchdog request clear pulse

    // Bank instances, one per 32 inputs
    genvar b;
    generate
        for (b = 0; b < 2; b++)
        begin : g_bank
            idcw_chg_bank u_bank
            (
                .pclk      (pclk),
                .presetn   (presetn),
                .energised (isolated_input_channel[32*b +: 32]),
                .enable    (q.chg_en[32*b +: 32]),
                .clr       (bank_clr[b]),
                .level     (in_level[32*b +: 32]),
                .latch     (in_latch[32*b +: 32]),
                .pend      (bank_pend[b])
            );
        end
    endgenerate

    // Bus strobes; every access completes with no wait
    assign setup = psel && !penable;
    assign wr    = psel && penable && pwrite;
    assign bank_clr[0] = wr && paddr == idcw_pkg::OFS_INT_STAT
                         && pwdata[idcw_pkg::INT_CHG0_BIT];
    assign bank_clr[1] = wr && paddr == idcw_pkg::OFS_INT_STAT
                         && pwdata[idcw_pkg::INT_CHG1_BIT];
    assign wdt_clr     = wr && paddr == idcw_pkg::OFS_INT_STAT
                         && pwdata[idcw_pkg::INT_WDT_BIT];

    // Read mux, sampled in the setup cycle
    always_comb
    begin
        rd  = idcw_pkg::WORD_ZERO;
        err = 1'b0;
        case (paddr)
            idcw_pkg::OFS_INT_STAT:   rd = {28'h0, q.wdt_carry, q.wdt_pend, bank_pend};
            idcw_pkg::OFS_ISO_IN_B0:  rd = in_level[31:0];
            idcw_pkg::OFS_ISO_IN_B1:  rd = in_level[63:32];
            idcw_pkg::OFS_CHG_EN_B0:  rd = q.chg_en[31:0];
            idcw_pkg::OFS_CHG_EN_B1:  rd = q.chg_en[63:32];
            idcw_pkg::OFS_CHG_LAT_B0: rd = in_latch[31:0];
            idcw_pkg::OFS_CHG_LAT_B1: rd = in_latch[63:32];
            idcw_pkg::OFS_TTL_DIR:    rd = q.ttl_dir;
            idcw_pkg::OFS_TTL_OUT:    rd = q.ttl_out;
            idcw_pkg::OFS_TTL_IN:     rd = q.ttl_s2;
            idcw_pkg::OFS_DO_LO:      rd = k_q.dout[31:0];
            idcw_pkg::OFS_DO_HI:      rd = k_q.dout[63:32];
            idcw_pkg::OFS_INIT_LO:    rd = k_q.init[31:0];
            idcw_pkg::OFS_INIT_HI:    rd = k_q.init[63:32];
            idcw_pkg::OFS_SAFE_LO:    rd = k_q.safe[31:0];
            idcw_pkg::OFS_SAFE_HI:    rd = k_q.safe[63:32];
            idcw_pkg::OFS_WDT_LOAD:   rd = q.wdt_load;
            idcw_pkg::OFS_CTRL:       rd = {29'h0, k_q.hold, k_q.safe_en, q.wdt_en};
            idcw_pkg::OFS_WDT_COUNT:  rd = q.wdt_cnt;
            idcw_pkg::OFS_BOARD_ID:   rd = {28'h0, ~q.id_s2};
            default:                  err = 1'b1;
        endcase
    end

    // Watchdog step and expiry
    assign tick = q.presc == idcw_pkg::WDT_TICK_LAST;
    assign ovf  = q.wdt_en && !q.wdt_carry && tick && q.wdt_cnt <= 32'h1;

    // Core next state
    always_comb
    begin
        d = q;
        // Pin synchronisers
        d.ttl_s1 = ttl_channel_i;
        d.ttl_s2 = q.ttl_s1;
        d.id_s1  = board_id_switch_on;
        d.id_s2  = q.id_s1;
        d.apply_pend = 1'b0;
        // Bus answer
        if (setup)
        begin
            d.prdata  = rd;
            d.pslverr = err;
        end
        // Prescaler free runs so steps are exactly 100 ns apart
        d.presc = tick ? 3'h0 : q.presc + 3'h1;
        // Count down while enabled
        if (q.wdt_en && !q.wdt_carry && tick)
        begin
            if (ovf)
            begin
                d.wdt_cnt   = 32'h0;
                d.wdt_carry = 1'b1;
            end
            else
                d.wdt_cnt = q.wdt_cnt - 32'h1;
        end
        // Software clears the request; an overflow in the same cycle wins
        if (wdt_clr)
            d.wdt_pend = 1'b0;
        if (ovf && (!q.wdt_pend || wdt_clr))
            d.wdt_pend = 1'b1;
        // Register writes
        if (wr)
        begin
            case (paddr)
                idcw_pkg::OFS_CHG_EN_B0: d.chg_en[31:0]  = pwdata;
                idcw_pkg::OFS_CHG_EN_B1: d.chg_en[63:32] = pwdata;
                idcw_pkg::OFS_TTL_DIR:   d.ttl_dir = pwdata;
                idcw_pkg::OFS_TTL_OUT:   d.ttl_out = pwdata;
                idcw_pkg::OFS_WDT_LOAD:
                begin
                    // Reload restarts the count and drops the carry
                    d.wdt_load  = pwdata;
                    d.wdt_cnt   = pwdata;
                    d.wdt_carry = 1'b0;
                end
                idcw_pkg::OFS_CTRL:      d.wdt_en = pwdata[idcw_pkg::CTRL_WDT_EN];
                default:                 d.wdt_en = q.wdt_en;
            endcase
        end
    end

    // Kept outputs and their setup
    always_comb
    begin
        k_d = k_q;
        // First cycle after a hot reset: reload unless hold is set and no cold start came before
        if (q.apply_pend)
        begin
            if (k_q.cold || !k_q.hold)
                k_d.dout = k_q.init;
            k_d.cold = 1'b0;
        end
        if (wr)
        begin
            case (paddr)
                idcw_pkg::OFS_DO_LO:   k_d.dout[31:0]  = pwdata;
                idcw_pkg::OFS_DO_HI:   k_d.dout[63:32] = pwdata;
                idcw_pkg::OFS_INIT_LO: k_d.init[31:0]  = pwdata;
                idcw_pkg::OFS_INIT_HI: k_d.init[63:32] = pwdata;
                idcw_pkg::OFS_SAFE_LO: k_d.safe[31:0]  = pwdata;
                idcw_pkg::OFS_SAFE_HI: k_d.safe[63:32] = pwdata;
                idcw_pkg::OFS_CTRL:
                begin
                    k_d.safe_en = pwdata[idcw_pkg::CTRL_SAFE_EN];
                    k_d.hold    = pwdata[idcw_pkg::CTRL_HOLD];
                end
                default:               k_d.hold = k_q.hold;
            endcase
        end
        // Safety values override a software write in the same cycle
        if (ovf && (!q.wdt_pend || wdt_clr) && k_q.safe_en)
            k_d.dout = k_q.safe;
    end

    // Core register, cleared by the hot reset only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.apply_pend <= 1'b1;
        end
        else
            q <= d;
    end

    // Kept register; only a cold start clears it
    always_ff @(posedge pclk or negedge power_on_rstn)
    begin
        if (!power_on_rstn)
        begin
            k_q <= '0;
            k_q.init <= idcw_pkg::INIT_RST;
            k_q.safe <= idcw_pkg::SAFE_RST;
            k_q.cold <= 1'b1;
        end
        else
            k_q <= k_d;
    end

    // Outputs
    assign prdata  = q.prdata;
    assign pslverr = q.pslverr;
    assign pready  = 1'b1;
    assign isolated_output_channel = k_q.dout;
    assign ttl_channel_o  = q.ttl_out;
    assign ttl_channel_oe = q.ttl_dir;
    assign irq = |bank_pend || q.wdt_pend;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_wdt_expire;
        q.wdt_en && !q.wdt_carry && tick && q.wdt_cnt == 32'h1 && !wr |=> q.wdt_carry;
    endproperty
    a_wdt_expire: assert property (p_wdt_expire) else $error("no overflow");

    property p_wdt_pend;
        $rose(q.wdt_carry) && !$past(q.wdt_pend) |-> q.wdt_pend && irq;
    endproperty
    a_wdt_pend: assert property (p_wdt_pend) else $error("overflow not raised");

    property p_wdt_step;
        q.wdt_en && !q.wdt_carry && q.wdt_cnt > 32'h4 && !wr && tick ##1 (!wr) [*3]
        |=> q.wdt_cnt == $past(q.wdt_cnt, 4) - 32'h1;
    endproperty
    a_wdt_step: assert property (p_wdt_step) else $error("bad count step");

    property p_wdt_reload;
        wr && paddr == idcw_pkg::OFS_WDT_LOAD |=> !q.wdt_carry && q.wdt_cnt == $past(pwdata);
    endproperty
    a_wdt_reload: assert property (p_wdt_reload) else $error("reload failed");

    property p_wdt_off;
        !q.wdt_en && !wr |=> $stable(q.wdt_cnt);
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("counting while off");

    property p_safety;
        $rose(q.wdt_pend) && k_q.safe_en |-> isolated_output_channel == k_q.safe;
    endproperty
    a_safety: assert property (p_safety) else $error("safety not applied");

    property p_clr_zero;
        q.wdt_pend && wr && paddr == idcw_pkg::OFS_INT_STAT
        && !pwdata[idcw_pkg::INT_WDT_BIT] |=> q.wdt_pend;
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("zero write cleared");

    property p_hold;
        q.apply_pend && k_q.hold && !k_q.cold && !wr |=> $stable(isolated_output_channel);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs not held");

    // Software tells the banks apart from the status word
    property p_bank_stat;
        setup && paddr == idcw_pkg::OFS_INT_STAT |=> prdata[1:0] == $past(bank_pend);
    endproperty
    a_bank_stat: assert property (p_bank_stat) else $error("bank status wrong");

    c_wdt_ovf:  cover property ($rose(q.wdt_pend));
    c_safety:   cover property ($rose(q.wdt_pend) && k_q.safe_en);
    c_both_bank: cover property (bank_pend == 2'b11);
    c_hot_hold: cover property (q.apply_pend && k_q.hold && !k_q.cold);
endmodule
`default_nettype wire

// ### logic/idcw_pkg.sv
`default_nettype none
package idcw_pkg;
    // Clock and watchdog timing
    localparam int CLK_MHZ = 40;                     // pclk rate
    localparam int WDT_TICK_NS = 100;                // Watchdog count step
    localparam int WDT_TICK_CYC = (WDT_TICK_NS * CLK_MHZ) / 1000;
    localparam logic [2:0] WDT_TICK_LAST = 3'(WDT_TICK_CYC - 1);

    // Register byte offsets
    localparam logic [7:0] OFS_INT_STAT    = 8'h00;  // Pending flags, write 1 to clear
    localparam logic [7:0] OFS_ISO_IN_B0   = 8'h04;  // Bank 0 input levels
    localparam logic [7:0] OFS_ISO_IN_B1   = 8'h08;  // Bank 1 input levels
    localparam logic [7:0] OFS_CHG_EN_B0   = 8'h0C;  // Bank 0 per-line detect enable
    localparam logic [7:0] OFS_CHG_EN_B1   = 8'h10;  // Bank 1 per-line detect enable
    localparam logic [7:0] OFS_CHG_LAT_B0  = 8'h14;  // Bank 0 captured word
    localparam logic [7:0] OFS_CHG_LAT_B1  = 8'h18;  // Bank 1 captured word
    localparam logic [7:0] OFS_TTL_DIR     = 8'h1C;  // 1 = channel drives
    localparam logic [7:0] OFS_TTL_OUT     = 8'h20;  // Drive values
    localparam logic [7:0] OFS_TTL_IN      = 8'h24;  // Pin levels
    localparam logic [7:0] OFS_DO_LO       = 8'h28;  // Outputs 31..0
    localparam logic [7:0] OFS_DO_HI       = 8'h2C;  // Outputs 63..32
    localparam logic [7:0] OFS_INIT_LO     = 8'h30;  // Power-up values 31..0
    localparam logic [7:0] OFS_INIT_HI     = 8'h34;  // Power-up values 63..32
    localparam logic [7:0] OFS_SAFE_LO     = 8'h38;  // Safety values 31..0
    localparam logic [7:0] OFS_SAFE_HI     = 8'h3C;  // Safety values 63..32
    localparam logic [7:0] OFS_WDT_LOAD    = 8'h40;  // Reload value, write reloads
    localparam logic [7:0] OFS_CTRL        = 8'h44;  // Enables and hold option
    localparam logic [7:0] OFS_WDT_COUNT   = 8'h48;  // Live count
    localparam logic [7:0] OFS_BOARD_ID    = 8'h4C;  // Switch identifier

    // Field positions
    localparam int INT_CHG0_BIT  = 0;
    localparam int INT_CHG1_BIT  = 1;
    localparam int INT_WDT_BIT   = 2;
    localparam int INT_CARRY_BIT = 3;
    localparam int CTRL_WDT_EN   = 0;
    localparam int CTRL_SAFE_EN  = 1;
    localparam int CTRL_HOLD     = 2;

    // Values after reset
    localparam logic [63:0] INIT_RST  = 64'h0;
    localparam logic [63:0] SAFE_RST  = 64'h0;
    localparam logic [31:0] LATCH_CLR = 32'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0;
    localparam logic [31:0] WDT_RST   = 32'h0;

    // One input bank
    typedef struct packed {
        logic [31:0] sync1;   // First synchroniser stage
        logic [31:0] sync2;   // Second synchroniser stage
        logic [31:0] prev;    // Previous sample for edge compare
        logic [31:0] latch;   // Captured word
        logic        pend;    // Request pending
    } idcw_bank_s;

    // Core state cleared by hot reset
    typedef struct packed {
        logic [31:0] ttl_s1;
        logic [31:0] ttl_s2;
        logic [3:0]  id_s1;
        logic [3:0]  id_s2;
        logic [63:0] chg_en;
        logic [31:0] ttl_dir;
        logic [31:0] ttl_out;
        logic [31:0] wdt_load;
        logic [31:0] wdt_cnt;
        logic [2:0]  presc;
        logic        wdt_en;
        logic        wdt_carry;
        logic        wdt_pend;
        logic        apply_pend;
        logic [31:0] prdata;
        logic        pslverr;
    } idcw_core_s;

    // State kept through hot reset
    typedef struct packed {
        logic [63:0] dout;
        logic [63:0] init;
        logic [63:0] safe;
        logic        hold;
        logic        safe_en;
        logic        cold;
    } idcw_keep_s;
endpackage
`default_nettype wire

// ### logic/idcw_chg_bank.sv
`timescale 1ns/1ps
`default_nettype none
module idcw_chg_bank
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] energised,   // Pin level, high when energised
    input  wire logic [31:0] enable,      // Per-line detect enable
    input  wire logic        clr,         // Clear pulse from software
    output logic      [31:0] level,       // 0 energised, 1 idle
    output logic      [31:0] latch,       // Captured word
    output logic             pend         // Request pending
);
    idcw_pkg::idcw_bank_s q;
    idcw_pkg::idcw_bank_s d;
    logic [31:0]          edges;
    logic                 evt;

    // Next state
    always_comb
    begin
        d = q;
        d.sync1 = energised;
        d.sync2 = q.sync1;
        d.prev  = q.sync2;
        edges   = (q.sync2 ^ q.prev) & enable;
        evt     = |edges;
        // A new event in the clear cycle wins over the clear
        if (evt && (!q.pend || clr))
        begin
            d.pend  = 1'b1;
            d.latch = ~q.sync2;
        end
        else if (clr)
        begin
            d.pend  = 1'b0;
            d.latch = idcw_pkg::LATCH_CLR;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    // Idle input reads 1
    assign level = ~q.sync2;
    assign latch = q.latch;
    assign pend  = q.pend;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_chg_capture;
        evt && !q.pend |=> pend && latch == $past(level);
    endproperty
    a_chg_capture: assert property (p_chg_capture) else $error("capture missed");

    property p_chg_erase;
        clr && !evt |=> !pend && latch == idcw_pkg::LATCH_CLR;
    endproperty
    a_chg_erase: assert property (p_chg_erase) else $error("latch not erased");

    property p_chg_ignore;
        q.pend && !clr |=> pend && $stable(latch);
    endproperty
    a_chg_ignore: assert property (p_chg_ignore) else $error("event not ignored");

    property p_chg_masked;
        enable == '0 && !q.pend |=> !pend;
    endproperty
    a_chg_masked: assert property (p_chg_masked) else $error("masked line fired");

    c_chg_event: cover property (evt && !q.pend);
endmodule
`default_nettype wire

// ### sim/idcw_host_apb.sv
`timescale 1ns/1ps
`default_nettype none
// Host side bus master, one transfer at a time
module idcw_host_apb
(
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic      [7:0]  paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata
);
    // Idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Setup, then access held until pready; released lines carry junk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### sim/idcw_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the isolated I/O card logic
module idcw_tb_top;
    logic        pclk, presetn, power_on_rstn, psel, penable, pwrite;
    logic        pready, pslverr, err, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, v, old;
    logic [31:0] ttl_ext;         // Far-end drive on TTL pins
    logic [31:0] ttl_o, ttl_oe;
    logic [31:0] ttl_pin;         // Resolved TTL wire
    logic [63:0] din;             // Energised isolated inputs
    logic [63:0] dout;
    logic [3:0]  sw_on;
    logic [31:0] mdl [0:19];      // Model of register words
    logic [7:0]  rwl [0:5];
    int          n_mismatch, n_compared, cyc, n, k;
    integer      seed;

    // Both parties resolved onto the TTL wire
    assign ttl_pin = (ttl_oe & ttl_o) | (~ttl_oe & ttl_ext);

    idcw_top DUT (.pclk(pclk), .presetn(presetn), .power_on_rstn(power_on_rstn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .isolated_input_channel(din), .isolated_output_channel(dout),
        .ttl_channel_i(ttl_pin), .ttl_channel_o(ttl_o), .ttl_channel_oe(ttl_oe),
        .board_id_switch_on(sw_on), .irq(irq));

    idcw_host_apb host (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata));

    // Clock, 25 ns period
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Hang guard, well above the planned run
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic test_done();
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Word compare
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Write, then let the effect settle before ports are looked at
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
        mdl[a[6:2]] = d;
        @(negedge pclk);
    endtask

    // Read and compare, no error response expected
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, rd, err);
        chk(nm, e, rd);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask

    // Hot reset pulse
    task automatic hrst();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    initial
    begin
        {presetn, power_on_rstn} = 2'b00;
        {din, ttl_ext, sw_on} = '0;
        {n_mismatch, n_compared, cyc} = '0;
        seed = 32'h79AD651D;
        rwl = '{idcw_pkg::OFS_DO_LO, idcw_pkg::OFS_DO_HI, idcw_pkg::OFS_INIT_LO,
                idcw_pkg::OFS_INIT_HI, idcw_pkg::OFS_SAFE_LO, idcw_pkg::OFS_SAFE_HI};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        power_on_rstn <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc("ctrl", idcw_pkg::OFS_CTRL, 32'h0);
        rdc("chg_en0", idcw_pkg::OFS_CHG_EN_B0, 32'h0);
        rdc("chg_en1", idcw_pkg::OFS_CHG_EN_B1, 32'h0);
        rdc("in1", idcw_pkg::OFS_ISO_IN_B1, 32'hFFFFFFFF);
        host.xfer(1'b0, 8'hF0, 32'h0, rd, err);
        chk("unmapped", 32'h1, {31'h0, err});
        // Every switch code
        for (int i = 0; i < 16; i++)
        begin
            sw_on <= 4'(i);
            repeat (3) @(posedge pclk);
            rdc("board_id", idcw_pkg::OFS_BOARD_ID, {28'h0, ~4'(i)});
        end
        // Random directions and drive values
        repeat (4)
        begin
            wr(idcw_pkg::OFS_TTL_DIR, $random(seed));
            wr(idcw_pkg::OFS_TTL_OUT, $random(seed));
            chk("ttl_oe", mdl[7], ttl_oe);
            chk("ttl_o", mdl[8], ttl_o);
            @(posedge pclk);
            ttl_ext <= $random(seed);
            repeat (3) @(posedge pclk);
            rdc("ttl_in", idcw_pkg::OFS_TTL_IN, ttl_pin);
        end
        // Output, power-up and safety words
        for (int i = 0; i < 6; i++) wr(rwl[i], $random(seed));
        for (int i = 0; i < 6; i++) rdc("rw", rwl[i], mdl[rwl[i][6:2]]);
        chk("dout_lo", mdl[10], dout[31:0]);
        // Hot reset without hold loads the power-up words
        wr(idcw_pkg::OFS_CTRL, 32'h0);
        hrst();
        chk("init_lo", mdl[12], dout[31:0]);
        chk("init_hi", mdl[13], dout[63:32]);
        // Hold keeps a fresh output word through hot reset
        wr(idcw_pkg::OFS_DO_LO, $random(seed));
        wr(idcw_pkg::OFS_CTRL, 32'h1 << idcw_pkg::CTRL_HOLD);
        hrst();
        chk("hold_lo", mdl[10], dout[31:0]);
        chk("hold_hi", mdl[13], dout[63:32]);
        // Change detect on each bank
        for (int b = 0; b < 2; b++)
        begin
            k = $random(seed) & 31;
            wr(idcw_pkg::OFS_CHG_EN_B0 + 8'(4 * b), 32'h1 << k);
            @(posedge pclk);
            din[32 * b + ((k + 1) & 31)] <= 1'b1;
            repeat (8) @(posedge pclk);
            chk("irq_off", 32'h0, {31'h0, irq});
            din[32 * b + k] <= ~din[32 * b + k];
            n = 0;
            while (irq !== 1'b1 && n < 8)
            begin
                @(posedge pclk);
                n++;
            end
            chk("chg_lat", 32'h1, 32'(n <= 6));
            old = ~din[32 * b +: 32];
            rdc("int_stat", idcw_pkg::OFS_INT_STAT, 32'h1 << b);
            rdc("latch", idcw_pkg::OFS_CHG_LAT_B0 + 8'(4 * b), old);
            @(posedge pclk);
            din[32 * b + k] <= ~din[32 * b + k];
            repeat (8) @(posedge pclk);
            rdc("latch_kept", idcw_pkg::OFS_CHG_LAT_B0 + 8'(4 * b), old);
            wr(idcw_pkg::OFS_INT_STAT, 32'h0);
            rdc("clr_zero", idcw_pkg::OFS_INT_STAT, 32'h1 << b);
            wr(idcw_pkg::OFS_INT_STAT, 32'h1 << b);
            rdc("latch_erased", idcw_pkg::OFS_CHG_LAT_B0 + 8'(4 * b), 32'h0);
            chk("irq_clr", 32'h0, {31'h0, irq});
            wr(idcw_pkg::OFS_CHG_EN_B0 + 8'(4 * b), 32'h0);
        end
        // Watchdog overflow with safety outputs
        wr(idcw_pkg::OFS_WDT_LOAD, 32'h5);
        wr(idcw_pkg::OFS_CTRL, 32'h3);
        n = 0;
        while (irq !== 1'b1 && n < 60)
        begin
            @(posedge pclk);
            n++;
        end
        chk("wdt_time", 32'h1, 32'(n >= 14 && n <= 24));
        rdc("wdt_stat", idcw_pkg::OFS_INT_STAT, 32'hC);
        chk("safe_lo", mdl[14], dout[31:0]);
        chk("safe_hi", mdl[15], dout[63:32]);
        wr(idcw_pkg::OFS_WDT_LOAD, 32'hC8);
        wr(idcw_pkg::OFS_INT_STAT, 32'h1 << idcw_pkg::INT_WDT_BIT);
        rdc("wdt_clr", idcw_pkg::OFS_INT_STAT, 32'h0);
        host.xfer(1'b0, idcw_pkg::OFS_WDT_COUNT, 32'h0, v, err);
        repeat (20) @(posedge pclk);
        host.xfer(1'b0, idcw_pkg::OFS_WDT_COUNT, 32'h0, rd, err);
        chk("wdt_run", 32'h1, 32'(rd < v && v <= 32'hC8));
        // Reloads well inside the interval keep the request away
        repeat (6)
        begin
            wr(idcw_pkg::OFS_WDT_LOAD, 32'h8);
            repeat (10) @(posedge pclk);
        end
        chk("wdt_fed", 32'h0, {31'h0, irq});
        chk("irq_idle", 32'h0, {31'h0, irq});
        test_done();
    end
endmodule
`default_nettype wire
